/* File: verilog/ttri_consts.vh */
`ifndef TTRI_CONSTS_VH
`define TTRI_CONSTS_VH

// ****************************************
// Symbol codes held in the encoder pipeline
// ****************************************
`define TTRI_CODE_ZERO 2'h0
`define TTRI_CODE_MARK 2'h1
`define TTRI_CODE_VIOL 2'h2
`define TTRI_CODE_BIP 2'h3

// ****************************************
// Pipeline shape
// ****************************************
`define TTRI_CODE_W 2
`define TTRI_PIPE_SLOTS 4
`define TTRI_PIPE_W 8
`define TTRI_OUT_SLOT 3
`define TTRI_B3_BIP_SLOT 2
`define TTRI_HDB3_BIP_SLOT 3

// ****************************************
// Positions in the synchronised input bundle
// ****************************************
`define TTRI_IN_W 6
`define TTRI_IN_CLK 0
`define TTRI_IN_POS 1
`define TTRI_IN_NEG 2
`define TTRI_IN_HOST 3
`define TTRI_IN_RISE 4
`define TTRI_IN_HDB3 5

// ****************************************
// Edge finder warm-up after reset
// ****************************************
`define TTRI_WARM_W 3

// ****************************************
// Dual-rail hold: bit periods a negative-rail one keeps the encoder off
// ****************************************
`define TTRI_DUAL_HOLD_BITS 32
`define TTRI_DUAL_HOLD_W 6

`endif

/* File: verilog/ttri_sync.v */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Two-stage synchroniser for a bundle of asynchronous levels
// ****************************************
module ttri_sync #(
  parameter WIDTH = 1
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule // ttri_sync

`default_nettype wire

/* File: verilog/ttri_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "ttri_consts.vh"

module ttri_top #(
  parameter DUAL_HOLD_BITS = `TTRI_DUAL_HOLD_BITS,
  parameter HOLD_W = `TTRI_DUAL_HOLD_W
) (
  input wire CLK_I,
  input wire RESET_N_I,
  input wire TX_TERMINAL_CLOCK_I,
  input wire TX_POSITIVE_RAIL_IN_I,
  input wire TX_NEGATIVE_RAIL_IN_I,
  input wire HOST_MODE_I,
  input wire SAMPLE_ON_RISING_I,
  input wire HDB3_SELECT_I,
  output reg LINE_OUT_TIP_O,
  output reg LINE_OUT_RING_O,
  output reg ENCODER_ACTIVE_O
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Picks one symbol code out of the packed pipeline
  function [`TTRI_CODE_W-1:0] slot_code;
    input [`TTRI_PIPE_W-1:0] pipe;
    input integer idx;
    reg [`TTRI_PIPE_W-1:0] shifted;
    begin
      shifted = pipe >> (idx * `TTRI_CODE_W);
      slot_code = shifted[`TTRI_CODE_W-1:0];
    end
  endfunction

  // True for symbols that carry an alternating pulse
  function is_alt_pulse;
    input [`TTRI_CODE_W-1:0] code;
    begin
      is_alt_pulse = (code == `TTRI_CODE_MARK) || (code == `TTRI_CODE_BIP);
    end
  endfunction

  // ****************************************
  // Input synchronisation
  // ****************************************

  wire [`TTRI_IN_W-1:0] in_async;
  wire [`TTRI_IN_W-1:0] in_sync;

  assign in_async = {HDB3_SELECT_I, SAMPLE_ON_RISING_I, HOST_MODE_I,
                     TX_NEGATIVE_RAIL_IN_I, TX_POSITIVE_RAIL_IN_I, TX_TERMINAL_CLOCK_I};

  // Every pin but CLK_I and RESET_N_I passes two flops before any logic looks at it
  ttri_sync #(
    .WIDTH(`TTRI_IN_W)
  ) u_sync (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .async_i(in_async),
    .sync_o(in_sync)
  );

  wire tclk = in_sync[`TTRI_IN_CLK];
  wire pos_rail = in_sync[`TTRI_IN_POS];
  wire neg_rail = in_sync[`TTRI_IN_NEG];
  wire host_mode = in_sync[`TTRI_IN_HOST];
  wire rise_sel = in_sync[`TTRI_IN_RISE];
  wire hdb3_sel = in_sync[`TTRI_IN_HDB3];

  // ****************************************
  // Transmit clock edge detection
  // ****************************************

  reg tclk_prev;
  reg [`TTRI_WARM_W-1:0] warm;

  // Previous clock level, used only for edge finding; warm fills with ones after reset
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tclk_prev <= 1'b0;
      warm <= {`TTRI_WARM_W{1'b0}};
    end else begin
      tclk_prev <= tclk;
      warm <= {warm[`TTRI_WARM_W-2:0], 1'b1};
    end
  end

  // A clock idling high would look like a rising edge against the reset value
  // of the previous sample, so edges count only once both samples are real
  wire armed = warm[`TTRI_WARM_W-1];
  wire tclk_rise = tclk & ~tclk_prev;
  wire tclk_fall = ~tclk & tclk_prev;
  // Rising edge only when host control asks for it; falling otherwise
  wire use_rise = host_mode & rise_sel;
  wire bit_strobe = armed & (use_rise ? tclk_rise : tclk_fall);

  // ****************************************
  // Single or dual rail detection
  // ****************************************

  reg [HOLD_W-1:0] dual_hold;
  wire [HOLD_W-1:0] hold_load = DUAL_HOLD_BITS[HOLD_W-1:0];
  // A rail tied low cannot be told from idle N data at one sample, so any one
  // seen on it keeps the encoder off for a while
  wire enc_en = (dual_hold == {HOLD_W{1'b0}}) & ~neg_rail;

  // Reload on every negative one, count down otherwise
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      dual_hold <= {HOLD_W{1'b0}};
    end else if (bit_strobe) begin
      if (neg_rail) begin
        dual_hold <= hold_load;
      end else if (dual_hold != {HOLD_W{1'b0}}) begin
        dual_hold <= dual_hold - {{(HOLD_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************
  // Encoder pipeline
  // ****************************************

  reg [`TTRI_PIPE_W-1:0] pipe_code;
  reg [`TTRI_PIPE_SLOTS-1:0] raw_pos;
  reg [`TTRI_PIPE_SLOTS-1:0] raw_neg;
  reg [`TTRI_PIPE_SLOTS-1:0] raw_mode;
  reg parity_odd;
  reg last_pos;

  reg [`TTRI_PIPE_W-1:0] next_pipe_code;
  reg [`TTRI_PIPE_SLOTS-1:0] next_raw_pos;
  reg [`TTRI_PIPE_SLOTS-1:0] next_raw_neg;
  reg [`TTRI_PIPE_SLOTS-1:0] next_raw_mode;
  reg next_parity_odd;
  reg next_last_pos;
  reg next_tip;
  reg next_ring;
  reg [`TTRI_CODE_W-1:0] new_code;
  reg [`TTRI_CODE_W-1:0] out_code;
  reg window_zero;
  reg eff_odd;
  integer bip_slot;

  // Shift in one bit, substitute zero runs, then emit the oldest slot
  always @* begin
    next_raw_pos = {raw_pos[`TTRI_PIPE_SLOTS-2:0], pos_rail};
    next_raw_neg = {raw_neg[`TTRI_PIPE_SLOTS-2:0], neg_rail};
    next_raw_mode = {raw_mode[`TTRI_PIPE_SLOTS-2:0], ~enc_en};
    // Only the positive rail carries data when encoding
    new_code = (enc_en & pos_rail) ? `TTRI_CODE_MARK : `TTRI_CODE_ZERO;
    next_pipe_code = {pipe_code[`TTRI_PIPE_W-`TTRI_CODE_W-1:0], new_code};
    // HDB3 looks for four zeros, B3ZS for three
    if (hdb3_sel) begin
      window_zero = (next_pipe_code == {`TTRI_PIPE_W{1'b0}}) &&
                    (next_raw_mode == {`TTRI_PIPE_SLOTS{1'b0}});
      bip_slot = `TTRI_HDB3_BIP_SLOT;
    end else begin
      window_zero = (next_pipe_code[`TTRI_PIPE_W-`TTRI_CODE_W-1:0] ==
                     {(`TTRI_PIPE_W-`TTRI_CODE_W){1'b0}}) &&
                    (next_raw_mode[`TTRI_PIPE_SLOTS-2:0] == {(`TTRI_PIPE_SLOTS-1){1'b0}});
      bip_slot = `TTRI_B3_BIP_SLOT;
    end
    // Pulse parity since the last violation, including the slot leaving now
    out_code = slot_code(next_pipe_code, `TTRI_OUT_SLOT);
    if (out_code == `TTRI_CODE_VIOL) begin
      eff_odd = 1'b0;
    end else begin
      eff_odd = parity_odd ^ is_alt_pulse(out_code);
    end
    // Odd count: V only; even count: B at window start plus V
    if (window_zero) begin
      next_pipe_code[`TTRI_CODE_W-1:0] = `TTRI_CODE_VIOL;
      if (!eff_odd) begin
        next_pipe_code = next_pipe_code |
          ({{(`TTRI_PIPE_W-`TTRI_CODE_W){1'b0}}, `TTRI_CODE_BIP} << (bip_slot * `TTRI_CODE_W));
      end
    end
    out_code = slot_code(next_pipe_code, `TTRI_OUT_SLOT);
    next_parity_odd = parity_odd;
    next_last_pos = last_pos;
    next_tip = 1'b0;
    next_ring = 1'b0;
    if (next_raw_mode[`TTRI_OUT_SLOT]) begin
      // Raw rails pass straight through; both high is driven as zero
      next_tip = next_raw_pos[`TTRI_OUT_SLOT] & ~next_raw_neg[`TTRI_OUT_SLOT];
      next_ring = next_raw_neg[`TTRI_OUT_SLOT] & ~next_raw_pos[`TTRI_OUT_SLOT];
    end else begin
      case (out_code)
        `TTRI_CODE_MARK, `TTRI_CODE_BIP: begin
          next_last_pos = ~last_pos;
          next_parity_odd = ~parity_odd;
          next_tip = ~last_pos;
          next_ring = last_pos;
        end
        `TTRI_CODE_VIOL: begin
          // Violation repeats the previous polarity
          next_parity_odd = 1'b0;
          next_tip = last_pos;
          next_ring = ~last_pos;
        end
        default: begin
          next_tip = 1'b0;
          next_ring = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Pipeline and line output registers
  // ****************************************

  // Pipeline and line outputs move once per bit and hold for the whole bit period; ENCODER_ACTIVE_O follows enc_en every clock
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pipe_code <= {`TTRI_PIPE_W{1'b0}};
      raw_pos <= {`TTRI_PIPE_SLOTS{1'b0}};
      raw_neg <= {`TTRI_PIPE_SLOTS{1'b0}};
      raw_mode <= {`TTRI_PIPE_SLOTS{1'b0}};
      parity_odd <= 1'b0;
      last_pos <= 1'b0;
      LINE_OUT_TIP_O <= 1'b0;
      LINE_OUT_RING_O <= 1'b0;
      ENCODER_ACTIVE_O <= 1'b0;
    end else begin
      ENCODER_ACTIVE_O <= enc_en;
      if (bit_strobe) begin
        pipe_code <= next_pipe_code;
        raw_pos <= next_raw_pos;
        raw_neg <= next_raw_neg;
        raw_mode <= next_raw_mode;
        parity_odd <= next_parity_odd;
        last_pos <= next_last_pos;
        LINE_OUT_TIP_O <= next_tip;
        LINE_OUT_RING_O <= next_ring;
      end
    end
  end

endmodule // ttri_top

`default_nettype wire

/* File: test/ttri_tb_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker for the transmit rail block
// ****************************************
module ttri_chk #(
  parameter DUAL_HOLD_BITS = 32
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic TX_TERMINAL_CLOCK_I,
  input wire logic TX_POSITIVE_RAIL_IN_I,
  input wire logic TX_NEGATIVE_RAIL_IN_I,
  input wire logic HOST_MODE_I,
  input wire logic SAMPLE_ON_RISING_I,
  input wire logic HDB3_SELECT_I,
  input wire logic LINE_OUT_TIP_O,
  input wire logic LINE_OUT_RING_O,
  input wire logic ENCODER_ACTIVE_O
);
  logic [5:0] pos_age;
  logic [5:0] neg_age;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Cycles since each rail was high; saturates so a long idle never wraps
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pos_age <= 6'h3F;
      neg_age <= 6'h3F;
    end else begin
      pos_age <= TX_POSITIVE_RAIL_IN_I ? 6'h00 : pos_age + {5'h00, pos_age != 6'h3F};
      neg_age <= TX_NEGATIVE_RAIL_IN_I ? 6'h00 : neg_age + {5'h00, neg_age != 6'h3F};
    end
  end
  one_pulse_a:
    assert property (!(LINE_OUT_TIP_O && LINE_OUT_RING_O)) else $error("tip and ring both high");
  reset_quiet_a:
    assert property ($rose(RESET_N_I) |-> !LINE_OUT_TIP_O && !LINE_OUT_RING_O && !ENCODER_ACTIVE_O)
    else $error("outputs busy after reset");
  falling_strobe_a:
    assert property (!(HOST_MODE_I && SAMPLE_ON_RISING_I) && $changed({LINE_OUT_TIP_O,
      LINE_OUT_RING_O}) |-> $past(TX_TERMINAL_CLOCK_I, 5) && !$past(TX_TERMINAL_CLOCK_I, 2))
    else $error("line moved off a falling edge");
  rising_strobe_a:
    assert property (HOST_MODE_I && SAMPLE_ON_RISING_I && $changed({LINE_OUT_TIP_O,
      LINE_OUT_RING_O}) |-> !$past(TX_TERMINAL_CLOCK_I, 5) && $past(TX_TERMINAL_CLOCK_I, 2))
    else $error("line moved off a rising edge");
  encoder_on_a:
    assert property ($rose(ENCODER_ACTIVE_O) |-> neg_age > 6'd5) else $error("encoder on early");
  encoder_off_a:
    assert property ($fell(ENCODER_ACTIVE_O) |-> neg_age < 6'd8) else $error("encoder off late");
  tip_cause_a:
    assert property ($rose(LINE_OUT_TIP_O) && !ENCODER_ACTIVE_O && !$past(ENCODER_ACTIVE_O, 30)
      |-> pos_age < 6'd40) else $error("raw tip pulse without a positive one");
  ring_cause_a:
    assert property ($rose(LINE_OUT_RING_O) && !ENCODER_ACTIVE_O && !$past(ENCODER_ACTIVE_O, 30)
      |-> neg_age < 6'd40) else $error("raw ring pulse without a negative one");
  raw_tip_c: cover property (!ENCODER_ACTIVE_O && $rose(LINE_OUT_TIP_O));
  encoder_c: cover property ($rose(ENCODER_ACTIVE_O));
  rising_c: cover property (HOST_MODE_I && SAMPLE_ON_RISING_I && $rose(LINE_OUT_RING_O));
endmodule // ttri_chk

bind ttri_top ttri_chk #(.DUAL_HOLD_BITS(DUAL_HOLD_BITS)) u_chk (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .TX_TERMINAL_CLOCK_I(TX_TERMINAL_CLOCK_I),
  .TX_POSITIVE_RAIL_IN_I(TX_POSITIVE_RAIL_IN_I), .TX_NEGATIVE_RAIL_IN_I(TX_NEGATIVE_RAIL_IN_I),
  .HOST_MODE_I(HOST_MODE_I), .SAMPLE_ON_RISING_I(SAMPLE_ON_RISING_I),
  .HDB3_SELECT_I(HDB3_SELECT_I), .LINE_OUT_TIP_O(LINE_OUT_TIP_O),
  .LINE_OUT_RING_O(LINE_OUT_RING_O), .ENCODER_ACTIVE_O(ENCODER_ACTIVE_O));
`default_nettype wire

/* File: test/ttri_framer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Terminal framer: one bit per 400 ns clock
// ****************************************
module ttri_framer_model (
  input wire logic rise_i,
  input wire logic tip_i,
  input wire logic ring_i,
  output wire logic tclk_o,
  output logic pos_o,
  output logic neg_o
);
  logic raw = 1'b0;
  logic [15:0] tip_seen = 16'h0000;
  logic [15:0] ring_seen = 16'h0000;
  // Clock stands still between frames; data moves on the edge away from sampling
  assign tclk_o = raw ^ rise_i;
  initial begin
    pos_o = 1'b0;
    neg_o = 1'b0;
  end
  // Send len bits first bit first, then four zeros that flush the line pipeline
  task automatic send(input logic [15:0] p, input logic [15:0] n, input int len);
    for (int i = 0; i < len + 4; i++) begin
      pos_o = (i < len) ? p[i] : 1'b0;
      neg_o = (i < len) ? (n[i] & ~p[i]) : 1'b0;
      raw = 1'b1;
      #100;
      if (i >= 4) begin
        tip_seen[i-4] = tip_i;
        ring_seen[i-4] = ring_i;
      end
      #100 raw = 1'b0;
      #200;
    end
    // Released: data line shows the inverse, the pulled-down rail sits low
    pos_o = ~pos_o;
    neg_o = 1'b0;
  endtask
endmodule // ttri_framer_model
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
  $display("wrong value at %0t got %h expected %h", $time, got, exp); end end
// ****************************************
// Bench for the transmit rail block
// ****************************************
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic host = 1'b0;
  logic rise_sel = 1'b0;
  logic hdb3 = 1'b0;
  wire tclk;
  wire pos;
  wire neg;
  wire tip;
  wire ring;
  wire enc;
  int err_total = 0;
  int checked = 0;
  // System clock, 50 ns
  initial begin
    forever #25 clk = ~clk;
  end
  ttri_framer_model fr (.rise_i(host & rise_sel), .tip_i(tip), .ring_i(ring),
    .tclk_o(tclk), .pos_o(pos), .neg_o(neg));
  ttri_top dut (.CLK_I(clk), .RESET_N_I(rst_n), .TX_TERMINAL_CLOCK_I(tclk),
    .TX_POSITIVE_RAIL_IN_I(pos), .TX_NEGATIVE_RAIL_IN_I(neg), .HOST_MODE_I(host),
    .SAMPLE_ON_RISING_I(rise_sel), .HDB3_SELECT_I(hdb3), .LINE_OUT_TIP_O(tip),
    .LINE_OUT_RING_O(ring), .ENCODER_ACTIVE_O(enc));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Mode pins are plain levels, so they settle while reset is held
  task automatic restart(input logic h, input logic s, input logic c);
    @(posedge clk);
    #1 rst_n = 1'b0;
    host = h;
    rise_sel = s;
    hdb3 = c;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Dual rail, default falling edge even with the rising select set
  task automatic dual_falling();
    restart(1'b0, 1'b1, 1'b0);
    fr.send(16'h0A52, 16'h0105, 12);
    `CHECK(fr.tip_seen & 16'h0FFF, 16'h0A52)
    `CHECK(fr.ring_seen & 16'h0FFF, 16'h0105)
    `CHECK(enc, 1'b0)
  endtask
  // Dual rail sampled on the rising edge under processor control
  task automatic dual_rising();
    restart(1'b1, 1'b1, 1'b0);
    fr.send(16'h0C30, 16'h0343, 12);
    `CHECK(fr.tip_seen & 16'h0FFF, 16'h0C30)
    `CHECK(fr.ring_seen & 16'h0FFF, 16'h0343)
  endtask
  // Single rail: 11 000 1 000 gives + - B0V - 00V
  task automatic b3zs_single();
    restart(1'b0, 1'b0, 1'b0);
    fr.send(16'h0023, 16'h0000, 9);
    `CHECK(fr.tip_seen & 16'h01FF, 16'h0015)
    `CHECK(fr.ring_seen & 16'h01FF, 16'h0122)
    `CHECK(enc, 1'b1)
  endtask
  // Single rail, falling edge chosen in host mode: + - B00V - 000V
  task automatic hdb3_single();
    restart(1'b1, 1'b0, 1'b1);
    fr.send(16'h0043, 16'h0000, 11);
    `CHECK(fr.tip_seen & 16'h07FF, 16'h0025)
    `CHECK(fr.ring_seen & 16'h07FF, 16'h0442)
    `CHECK(enc, 1'b1)
  endtask
  // Main sequence
  initial begin
    dual_falling();
    dual_rising();
    b3zs_single();
    hdb3_single();
    finish_test();
  end
  // Watchdog, well past the 30 us the sequence needs
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
endmodule // tb
`default_nettype wire
